// ---- rtl/serial_config_regs.svh ----
// What this block does
// - three-bit selector picks jack-sense mute pattern
// - selector 101 mutes per second sense input
// - forced mute overrides volume; active follows volume
// - sense reads 0 unplugged, 1 plugged
// - soft reset keeps link-related config bits
// - hard reset returns register to 0x1001
// - link bit ties spdif requests to front
// - underrun fill: repeat last or midscale
// - source bit picks link or ADC stream
// - swap bit exchanges centre and LFE
// - steering bit picks interrupt slot position
// - loop-back selector routes ADC to DAC pair
// - override bit forces spdif present
// - mic selector picks pins or mixes
// - codec target bits pick addressed codec
// - slot16 bit selects 16x16 link format
`ifndef SERIAL_CONFIG_REGS_SVH
`define SERIAL_CONFIG_REGS_SVH
`define SCFG_RESET_ADDR 7'h00
`define SCFG_ADDR 7'h74
`define SCFG_RESET_VAL 16'h1001
// bits kept across a soft reset: d15..d12, d7, d2..d0
`define SCFG_KEEP_MASK 16'hf087
`define SCFG_LINK_BIT 0
`define SCFG_FILL_BIT 1
`define SCFG_SRC_BIT 2
`define SCFG_SWAP_BIT 3
`define SCFG_INTERRUPT_STEERING_BIT 4
`define SCFG_LBK_LO 5
`define SCFG_OVR_BIT 7
`define SCFG_MIC_LO 8
`define SCFG_TGT3_BIT 11
`define SCFG_TGT_LO 12
`define SCFG_SLOT16_BIT 15
`endif

// ---- rtl/serial_config_pkg.sv ----
`default_nettype none
package serial_config_pkg;
    // loop-back destination
    typedef enum logic [1:0] {lbk_none, lbk_front, lbk_surround, lbk_center_lfe} lbk_route_t;
    // registered state of the block
    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] rdata;
        logic sense_a_m;
        logic sense_a_s;
        logic sense_b_m;
        logic sense_b_s;
    } state_t;
endpackage : serial_config_pkg
`default_nettype wire

// ---- rtl/jack_mute_decode.sv ----
`include "serial_config_regs.svh"
`default_nettype none
module jack_mute_decode (
    // selection and sense levels
    input wire logic [2:0] sense_mute_selector,
    input wire logic jack_sense_a,
    input wire logic jack_sense_b,
    // forced silence per output: hp, line, clfe, surr, mono
    output logic [4:0] forced_silence
);
    // upper mute selections decode
    always_comb begin
        forced_silence = 5'h00;
        unique case (sense_mute_selector)
            3'h4: begin
                unique case ({jack_sense_b, jack_sense_a})
                    2'h0: forced_silence = 5'h0e;
                    2'h1: forced_silence = 5'h01;
                    default: forced_silence = 5'h0f;
                endcase
            end
            3'h5: forced_silence = jack_sense_b ? 5'h01 : 5'h1e;
            default: forced_silence = 5'h00;
        endcase
    end
endmodule : jack_mute_decode
`default_nettype wire

// ---- rtl/serial_config.sv ----
`include "serial_config_regs.svh"
`default_nettype none
module serial_config (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register access from the link
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // jack sense pins and mute selection
    input wire logic jack_sense_a,
    input wire logic jack_sense_b,
    input wire logic [2:0] sense_mute_selector,
    input wire logic [4:0] volume_mute,
    output logic [4:0] forced_silence,
    output logic [4:0] output_muted,
    output logic jack_sense_a_status,
    output logic jack_sense_b_status,
    // audio path steering
    input wire logic loopback_enable,
    input wire logic front_data_request,
    input wire logic spdif_own_request,
    input wire logic spdif_detect_resistor,
    output logic spdif_data_request,
    output logic spdif_enabled,
    output logic spdif_underrun_fill,
    output logic spdif_source_select,
    output logic center_lfe_exchange,
    output logic interrupt_steering,
    output serial_config_pkg::lbk_route_t loopback_route,
    output logic [2:0] optional_mic_source,
    output logic [3:0] chained_codec_target,
    output logic slot16_mode
);
    serial_config_pkg::state_t st_r, st_nxt;
    logic [4:0] force_w;

    jack_mute_decode u_dec (
        .sense_mute_selector(sense_mute_selector),
        .jack_sense_a(st_r.sense_a_s),
        .jack_sense_b(st_r.sense_b_s),
        .forced_silence(force_w)
    );

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.sense_a_m = jack_sense_a;
        st_nxt.sense_a_s = st_r.sense_a_m;
        st_nxt.sense_b_m = jack_sense_b;
        st_nxt.sense_b_s = st_r.sense_b_m;
        if (reg_wr && reg_addr == `SCFG_ADDR) begin
            st_nxt.cfg = reg_wdata;
        end else if (reg_wr && reg_addr == `SCFG_RESET_ADDR) begin
            st_nxt.cfg = (st_r.cfg & `SCFG_KEEP_MASK) | (`SCFG_RESET_VAL & ~`SCFG_KEEP_MASK);
        end
        if (reg_rd) begin
            st_nxt.rdata = (reg_addr == `SCFG_ADDR) ? st_r.cfg : 16'h0000;
        end
    end

    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '{cfg: `SCFG_RESET_VAL, rdata: 16'h0000, default: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign jack_sense_a_status = st_r.sense_a_s;
    assign jack_sense_b_status = st_r.sense_b_s;
    assign forced_silence = force_w;
    assign output_muted = force_w | volume_mute;
    assign spdif_data_request = st_r.cfg[`SCFG_LINK_BIT] ? front_data_request
                                                          : spdif_own_request;
    assign spdif_underrun_fill = st_r.cfg[`SCFG_FILL_BIT];
    assign spdif_source_select = st_r.cfg[`SCFG_SRC_BIT];
    assign center_lfe_exchange = st_r.cfg[`SCFG_SWAP_BIT];
    assign interrupt_steering = st_r.cfg[`SCFG_INTERRUPT_STEERING_BIT];
    assign spdif_enabled = st_r.cfg[`SCFG_OVR_BIT] | spdif_detect_resistor;
    assign optional_mic_source = st_r.cfg[`SCFG_MIC_LO +: 3];
    assign chained_codec_target = {st_r.cfg[`SCFG_TGT3_BIT], st_r.cfg[`SCFG_TGT_LO +: 3]};
    assign slot16_mode = st_r.cfg[`SCFG_SLOT16_BIT];

    always_comb begin
        loopback_route = serial_config_pkg::lbk_none;
        if (loopback_enable) begin
            unique case (st_r.cfg[`SCFG_LBK_LO +: 2])
                2'h0: loopback_route = serial_config_pkg::lbk_front;
                2'h1: loopback_route = serial_config_pkg::lbk_surround;
                2'h2: loopback_route = serial_config_pkg::lbk_center_lfe;
                default: loopback_route = serial_config_pkg::lbk_none;
            endcase
        end
    end

    // register access steps seen by the checks below
    sequence soft_reset_s;
        reg_wr && reg_addr == `SCFG_RESET_ADDR;
    endsequence
    sequence cfg_write_s;
        reg_wr && reg_addr == `SCFG_ADDR;
    endsequence
    sequence cfg_read_s;
        reg_rd && reg_addr == `SCFG_ADDR;
    endsequence
    sequence other_read_s;
        reg_rd && reg_addr != `SCFG_ADDR;
    endsequence
    sequence other_write_s;
        reg_wr && reg_addr != `SCFG_ADDR && reg_addr != `SCFG_RESET_ADDR;
    endsequence

    // soft reset keeps link bits
    soft_keep_a: assert property (@(posedge clk) disable iff (!resetn)
        soft_reset_s |=> ((st_r.cfg & `SCFG_KEEP_MASK)
            == ($past(st_r.cfg) & `SCFG_KEEP_MASK)))
        else $error("soft reset changed kept bits");
    // soft reset restores the other bits
    soft_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        soft_reset_s |=> ((st_r.cfg & ~`SCFG_KEEP_MASK)
            == (`SCFG_RESET_VAL & ~`SCFG_KEEP_MASK)))
        else $error("soft reset left other bits");
    // write lands next cycle
    cfg_write_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg_write_s |=> (st_r.cfg == $past(reg_wdata)))
        else $error("config write lost");
    // writes elsewhere leave config alone
    other_write_a: assert property (@(posedge clk) disable iff (!resetn)
        other_write_s |=> (st_r.cfg == $past(st_r.cfg)))
        else $error("stray write changed config");
    // read returns the held word
    cfg_read_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg_read_s |=> (reg_rdata == $past(st_r.cfg)))
        else $error("config read wrong");
    // reads elsewhere return zero
    other_read_a: assert property (@(posedge clk) disable iff (!resetn)
        other_read_s |=> (reg_rdata == 16'h0000))
        else $error("stray read not zero");
    // default word right after reset
    rst_default_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> (st_r.cfg == `SCFG_RESET_VAL))
        else $error("reset default wrong");
    // selector 101 with b low
    mute_101_a: assert property (@(posedge clk) disable iff (!resetn)
        (sense_mute_selector == 3'h5 && !st_r.sense_b_s) |-> forced_silence == 5'h1e)
        else $error("selector 101 pattern wrong");
    // reserved codes force nothing
    mute_rsvd_a: assert property (@(posedge clk) disable iff (!resetn)
        (sense_mute_selector[2:1] == 2'h3) |-> forced_silence == 5'h00)
        else $error("reserved selector forced mute");
    // forced outputs muted
    mute_over_a: assert property (@(posedge clk) disable iff (!resetn)
        (output_muted & forced_silence) == forced_silence)
        else $error("forced output not muted");
    // sense reaches status after two clocks
    sense_sync_a: assert property (@(posedge clk) disable iff (!resetn)
        ##2 (jack_sense_a_status == $past(jack_sense_a, 2)))
        else $error("sense status wrong");
    // link tie
    link_tie_a: assert property (@(posedge clk) disable iff (!resetn)
        st_r.cfg[0] |-> spdif_data_request == front_data_request)
        else $error("spdif request not tied");
    // override
    ovr_a: assert property (@(posedge clk) disable iff (!resetn)
        st_r.cfg[7] |-> spdif_enabled)
        else $error("override ignored");
    // selector 101 with b high
    mute_101_hi_a: assert property (@(posedge clk) disable iff (!resetn)
        (sense_mute_selector == 3'h5 && st_r.sense_b_s) |-> forced_silence == 5'h01)
        else $error("selector 101 high pattern wrong");
    // selector 100 with no plug
    mute_100_lo_a: assert property (@(posedge clk) disable iff (!resetn)
        (sense_mute_selector == 3'h4 && !st_r.sense_b_s && !st_r.sense_a_s) |-> forced_silence == 5'h0e)
        else $error("selector 100 idle pattern wrong");
    // selector 100 with only a plugged
    mute_100_mono_a: assert property (@(posedge clk) disable iff (!resetn)
        (sense_mute_selector == 3'h4 && !st_r.sense_b_s && st_r.sense_a_s) |-> forced_silence == 5'h01)
        else $error("selector 100 front pattern wrong");
    // selector 100 with b plugged
    mute_100_rear_a: assert property (@(posedge clk) disable iff (!resetn)
        (sense_mute_selector == 3'h4 && st_r.sense_b_s) |-> forced_silence == 5'h0f)
        else $error("selector 100 rear pattern wrong");
    // active outputs follow volume
    mute_active_a: assert property (@(posedge clk) disable iff (!resetn)
        ((output_muted & ~forced_silence) == (volume_mute & ~forced_silence)))
        else $error("active output ignores volume");
    // second sense reaches status after two clocks
    sense_b_sync_a: assert property (@(posedge clk) disable iff (!resetn)
        ##2 (jack_sense_b_status == $past(jack_sense_b, 2)))
        else $error("sense b status wrong");
    // untied request runs on its own
    link_free_a: assert property (@(posedge clk) disable iff (!resetn)
        !st_r.cfg[0] |-> spdif_data_request == spdif_own_request)
        else $error("spdif request still tied");
    // resistor decides without override
    ovr_off_a: assert property (@(posedge clk) disable iff (!resetn)
        !st_r.cfg[7] |-> spdif_enabled == spdif_detect_resistor)
        else $error("spdif detect ignored");
    // loop-back off gives no route
    lbk_off_a: assert property (@(posedge clk) disable iff (!resetn)
        !loopback_enable |-> loopback_route == serial_config_pkg::lbk_none)
        else $error("loop-back route while off");
    // reserved loop-back code gives no route
    lbk_rsvd_a: assert property (@(posedge clk) disable iff (!resetn)
        (st_r.cfg[`SCFG_LBK_LO +: 2] == 2'h3) |-> loopback_route == serial_config_pkg::lbk_none)
        else $error("reserved loop-back routed");
    // slot16 output follows write
    slot16_write_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg_write_s |=> (slot16_mode == $past(reg_wdata[15])))
        else $error("slot16 mode not written");
    // codec target follows write
    target_write_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg_write_s |=> (chained_codec_target == {$past(reg_wdata[11]), $past(reg_wdata[14:12])}))
        else $error("codec target not written");
endmodule : serial_config
`default_nettype wire

// ---- sim/link_host.sv ----
`default_nettype none
module link_host (
    // clock
    input wire logic clk,
    // register access toward the codec
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h7f;
        reg_wdata = 16'hffff;
    end
    // whole-word accesses
    // one write, then lines show inverse
    task automatic write_reg(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : write_reg
    // one read, data taken after its edge
    task automatic read_reg(input logic [6:0] a, output logic [15:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : read_reg
endmodule : link_host
`default_nettype wire

// ---- sim/codec_serial_config_jack_mute_tb.sv ----
`default_nettype none
module codec_serial_config_jack_mute_tb;
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
        $display("unexpected at %0t got %h exp %h", $time, g, e); end end
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic reg_wr, reg_rd, jack_sense_a = 1'b0, jack_sense_b = 1'b0;
    logic [6:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd;
    logic [2:0] sense_mute_selector = 3'h0, optional_mic_source;
    logic [4:0] volume_mute = 5'h04, forced_silence, output_muted, fs;
    logic loopback_enable = 1'b1, front_data_request = 1'b1, spdif_own_request = 1'b0;
    logic spdif_detect_resistor = 1'b0, jack_sense_a_status, jack_sense_b_status;
    logic spdif_data_request, spdif_enabled, spdif_underrun_fill, spdif_source_select;
    logic center_lfe_exchange, interrupt_steering, slot16_mode;
    logic [3:0] chained_codec_target;
    serial_config_pkg::lbk_route_t loopback_route, lr;
    logic [15:0] vals [4] = '{16'hffff, 16'h0000, 16'h5a3a, 16'ha5c5};
    int error_cnt = 0, checks_done = 0, cycles = 0;
    // clock
    always #5 clk = ~clk;
    serial_config dut (.clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .jack_sense_a, .jack_sense_b, .sense_mute_selector, .volume_mute, .forced_silence,
        .output_muted, .jack_sense_a_status, .jack_sense_b_status, .loopback_enable,
        .front_data_request, .spdif_own_request, .spdif_detect_resistor, .spdif_data_request,
        .spdif_enabled, .spdif_underrun_fill, .spdif_source_select, .center_lfe_exchange,
        .interrupt_steering, .loopback_route, .optional_mic_source, .chained_codec_target,
        .slot16_mode);
    link_host host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    // verdict and end of run
    task automatic wrap_up();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    // read back and compare every field output
    task automatic check_cfg(input logic [15:0] v);
        lr = loopback_enable
            ? serial_config_pkg::lbk_route_t'((v[6:5] == 2'h3) ? 2'h0 : v[6:5] + 2'h1)
            : serial_config_pkg::lbk_none;
        host.read_reg(7'h74, rd);
        `CHK(rd, v)
        `CHK(spdif_data_request, v[0] ? front_data_request : spdif_own_request)
        `CHK(spdif_underrun_fill, v[1])
        `CHK(spdif_source_select, v[2])
        `CHK(center_lfe_exchange, v[3])
        `CHK(interrupt_steering, v[4])
        `CHK(loopback_route, lr)
        `CHK(spdif_enabled, v[7] | spdif_detect_resistor)
        `CHK(optional_mic_source, v[10:8])
        `CHK(chained_codec_target, {v[11], v[14:12]})
        `CHK(slot16_mode, v[15])
    endtask : check_cfg
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            wrap_up();
        end
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        #1;
        resetn = 1'b1;
        check_cfg(16'h1001);
        foreach (vals[i]) begin
            host.write_reg(7'h74, vals[i]);
            check_cfg(vals[i]);
        end
        host.write_reg(7'h74, 16'hffff);
        host.write_reg(7'h00, 16'h0000);
        check_cfg(16'hf087);
        host.write_reg(7'h31, 16'h0000);
        host.read_reg(7'h31, rd);
        `CHK(rd, 16'h0000)
        loopback_enable = 1'b0;
        check_cfg(16'hf087);
        `CHK(loopback_route, serial_config_pkg::lbk_none)
        spdif_detect_resistor = 1'b1;
        front_data_request = 1'b0;
        spdif_own_request = 1'b1;
        resetn = 1'b0;
        @(posedge clk);
        #1;
        resetn = 1'b1;
        check_cfg(16'h1001);
        for (int s = 4; s < 8; s++) begin
            for (int b = 0; b < 4; b++) begin
                sense_mute_selector = 3'(s);
                jack_sense_b = b[1];
                jack_sense_a = b[0];
                repeat (4) @(posedge clk);
                #1;
                fs = (s == 4) ? ((b == 0) ? 5'h0e : (b == 1) ? 5'h01 : 5'h0f)
                    : (s == 5) ? (b[1] ? 5'h01 : 5'h1e) : 5'h00;
                `CHK(forced_silence, fs)
                `CHK(output_muted, fs | volume_mute)
                `CHK({jack_sense_b_status, jack_sense_a_status}, b[1:0])
            end
        end
        wrap_up();
    end
endmodule : codec_serial_config_jack_mute_tb
`default_nettype wire
